// *** inc/ocmd_params.svh ***
/*
  Constants of the output lock and autoselect command interpreter:
  register offsets, field positions, reset values and sizes.
  Assumes inclusion by every design file that needs them.
*/
`ifndef OCMD_PARAMS_SVH
`define OCMD_PARAMS_SVH

// Register byte offsets on the Wishbone slave
`define OC_OFF_RX      8'h00
`define OC_OFF_TX      8'h04
`define OC_OFF_STAT    8'h08
`define OC_OFF_XPT     8'h0C
`define OC_OFF_MUTE    8'h10
`define OC_OFF_ASEL    8'h14

// Field positions
`define OC_STAT_OVR    1
`define OC_TX_VALID    8

// Sizes
`define OC_CMD_DEPTH   4'hC
`define OC_LAST_BYTE   4'hF
`define OC_RESP_DEPTH  32
`define OC_RESP_AW     5
`define OC_VID_INPUTS  3'h6
`define OC_AUD_INPUTS  3'h5
`define OC_OUT_NUMBER  "1"

// Reset values
`define OC_RST_SEL     3'h1
`define OC_RST_AS_EN   1'b0
`define OC_RST_NOSIG   1'b0

`endif

// *** inc/ocmd_pkg.sv ***
/*
  Types of the output lock and autoselect command interpreter.
  Assumes nothing of its surroundings.
*/
package ocmd_pkg;

  typedef logic [7:0] char_t;

  typedef enum logic [1:0] {
    MODE_PRIO,
    MODE_FIRST,
    MODE_LAST,
    MODE_STATIC
  } as_mode_t;

  typedef enum logic [2:0] {
    RK_LOCK,
    RK_UNLOCK,
    RK_VIEW,
    RK_SIZE,
    RK_ASEL,
    RK_ERR
  } resp_kind_t;

  typedef enum logic {
    ST_IDLE,
    ST_EMIT
  } emit_state_t;

endpackage

// *** hdl/char_fold.sv ***
/*
  Character folding for the command parser: lower case to upper case,
  and white space detection.
  Assumes ASCII input; purely combinational.
*/
`timescale 1ns/100ps

module char_fold (
  // Raw character
  input  wire logic [7:0] raw_i,
  // Folded character
  output logic      [7:0] upper_o,
  output logic            is_space_o
);

  wire is_lower_w = (raw_i >= 8'h61) && (raw_i <= 8'h7A);

  assign upper_o    = is_lower_w ? (raw_i - 8'h20) : raw_i;
  assign is_space_o = (raw_i == 8'h20) || (raw_i == 8'h09);

endmodule // char_fold

// *** hdl/resp_mem.sv ***
/*
  Response character memory: one write port, one read port, registered
  read data.
  Assumes the owner keeps the pointers and never reads an entry in the
  cycle after writing it.
*/
`timescale 1ns/100ps
`include "ocmd_params.svh"

module resp_mem (
  // Clock
  input  wire logic                   clk_i,
  // Write port
  input  wire logic                   wr_en_i,
  input  wire logic [`OC_RESP_AW-1:0] wr_addr_i,
  input  wire logic [7:0]             wr_data_i,
  // Read port
  input  wire logic [`OC_RESP_AW-1:0] rd_addr_i,
  output logic      [7:0]             rd_data_o
);

  logic [7:0] mem_q [`OC_RESP_DEPTH];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_q[rd_addr_i];
  end

endmodule // resp_mem

// *** hdl/output_lock_autoselect_commands.sv ***
/*
  Text command interpreter for the single output of a small crosspoint:
  lock, unlock, connection view, size and autoselect commands, plus a
  Wishbone classic register file for switching, muting and status.
  Assumes a Wishbone classic master on clk_i (same domain, no sync).
*/
// Overview of operation
// - Lock freezes layer; answer tag, output, layer
// - Unlock frees layer; answer tag, output, layer
// - Unlock answer identical whatever previous lock state
// - Both layers view: video line, then audio
// - View line: layer letter, two-digit input
// - Flag M muted, L locked, U both
// - Layer A audio, V video, AV/none both
// - Size answers one line per layer
// - Video six by one, audio five by one
// - Autoselect commands address output one
// - Video autoselect query answers three fields
// - Enable field E enabled, D disabled
// - Video mode P, K or L
// - Audio mode adds S static
// - No-signal B blank, M mute
// - Video autoselect change applied and echoed
// - Audio autoselect query answers three fields
// - Mute keeps crosspoint selection untouched
// - No grouped switch onto locked layer
`timescale 1ns/100ps
`include "ocmd_params.svh"

module output_lock_autoselect_commands (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Wishbone classic slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // Crosspoint state
  output logic      [2:0]         video_sel_o,
  output logic      [2:0]         audio_sel_o,
  output logic                    video_mute_o,
  output logic                    audio_mute_o,
  output logic                    video_lock_o,
  output logic                    audio_lock_o,
  // Autoselect settings
  output logic                    video_as_en_o,
  output ocmd_pkg::as_mode_t      video_as_mode_o,
  output logic                    video_as_nosig_mute_o,
  output logic                    audio_as_en_o,
  output ocmd_pkg::as_mode_t      audio_as_mode_o,
  output logic                    audio_as_nosig_mute_o
);
  import ocmd_pkg::*;

  logic                   ack_q;
  logic [31:0]            dat_q;
  char_t                  cmd_q [`OC_CMD_DEPTH];
  logic [3:0]             len_q;
  logic                   in_cmd_q;
  logic                   ovf_q;
  logic                   ovr_q;
  emit_state_t            state_q;
  resp_kind_t             kind_q;
  logic [1:0]             mask_q;
  logic [3:0]             idx_q;
  logic                   second_q;
  logic                   cur_audio_q;
  logic [1:0]             lock_q;
  logic                   vmute_q;
  logic                   amute_q;
  logic [2:0]             vsel_q;
  logic [2:0]             asel_q;
  logic                   vas_en_q;
  as_mode_t               vas_mode_q;
  logic                   vas_ns_q;
  logic                   aas_en_q;
  as_mode_t               aas_mode_q;
  logic                   aas_ns_q;
  logic [`OC_RESP_AW:0]   wr_ptr_q;
  logic [`OC_RESP_AW:0]   rd_ptr_q;
  logic [`OC_RESP_AW:0]   wr_seen_q;
  char_t                  mem_rd_w;
  char_t                  rx_char_w;
  logic                   rx_space_w;
  logic [127:0]           line_w;
  char_t                  line_byte_w [16];

  // Bus decode
  wire       req_w      = wb_cyc_i & wb_stb_i & ~ack_q;
  wire       wr_w       = req_w & wb_we_i;
  wire       rd_w       = req_w & ~wb_we_i;
  wire [7:0] off_w      = {wb_adr_i[7:2], 2'b00};
  wire       hit_rx_w   = off_w == `OC_OFF_RX;
  wire       hit_tx_w   = off_w == `OC_OFF_TX;
  wire       hit_stat_w = off_w == `OC_OFF_STAT;
  wire       hit_xpt_w  = off_w == `OC_OFF_XPT;
  wire       hit_mute_w = off_w == `OC_OFF_MUTE;
  wire       hit_asel_w = off_w == `OC_OFF_ASEL;
  wire       busy_w     = state_q == ST_EMIT;
  wire       rx_wr_w    = wr_w & hit_rx_w & wb_sel_i[0];
  wire       full_w     = (wr_ptr_q[`OC_RESP_AW] != rd_ptr_q[`OC_RESP_AW]) &&
                          (wr_ptr_q[`OC_RESP_AW-1:0] == rd_ptr_q[`OC_RESP_AW-1:0]);
  // Entries count as readable one cycle late so the registered read port has caught up
  wire       tx_valid_w = wr_seen_q != rd_ptr_q;
  wire       pop_w      = rd_w & hit_tx_w & tx_valid_w;

  char_fold u_fold (
    .raw_i      (wb_dat_i[7:0]),
    .upper_o    (rx_char_w),
    .is_space_o (rx_space_w)
  );

  // Character intake: characters arriving while a response is still being built are dropped
  wire take_w  = rx_wr_w & ~busy_w;
  wire open_w  = take_w & (rx_char_w == "{");
  wire close_w = take_w & in_cmd_q & (rx_char_w == "}");
  wire store_w = take_w & in_cmd_q & ~rx_space_w & ~open_w & ~close_w;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      len_q    <= 4'h0;
      in_cmd_q <= 1'b0;
      ovf_q    <= 1'b0;
    end else if (open_w) begin
      len_q    <= 4'h0;
      in_cmd_q <= 1'b1;
      ovf_q    <= 1'b0;
    end else if (close_w) begin
      in_cmd_q <= 1'b0;
    end else if (store_w) begin
      if (len_q == `OC_CMD_DEPTH) begin
        ovf_q <= 1'b1;
      end else begin
        len_q <= len_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (store_w && len_q != `OC_CMD_DEPTH) begin
      cmd_q[len_q] <= rx_char_w;
    end
  end

  // Command decode
  wire       is_lock_w   = (cmd_q[0] == "#") & (cmd_q[1] == ">");
  wire       is_unlock_w = (cmd_q[0] == "+") & (cmd_q[1] == "<");
  wire       two_dig_w   = (cmd_q[2] == "0") & (cmd_q[3] == "1");
  wire       lk_out_ok_w = two_dig_w | (cmd_q[2] == `OC_OUT_NUMBER);
  wire       is_vc_w     = (cmd_q[0] == "V") & (cmd_q[1] == "C");
  wire       is_size_w   = {cmd_q[0], cmd_q[1], cmd_q[2], cmd_q[3], cmd_q[4], cmd_q[5],
                            cmd_q[6]} == "GETSIZE";
  wire [3:0] lay_p_w     = (is_lock_w | is_unlock_w) ? (two_dig_w ? 4'h4 : 4'h3) :
                           is_vc_w ? 4'h2 : 4'h7;
  wire [3:0] rem_w       = len_q - lay_p_w;
  wire [7:0] la_w        = cmd_q[lay_p_w];
  wire [7:0] lb_w        = cmd_q[lay_p_w + 4'h1];
  // Bit 0 video, bit 1 audio; zero means a malformed layer
  wire [1:0] mask_w      = (rem_w == 4'h0) ? 2'b11 :
                           (rem_w == 4'h1) ? ((la_w == "A") ? 2'b10 :
                                              (la_w == "V") ? 2'b01 : 2'b00) :
                           ((rem_w == 4'h2) & (la_w == "A") & (lb_w == "V")) ? 2'b11 : 2'b00;

  wire       is_as_w     = ({cmd_q[0], cmd_q[1], cmd_q[2]} == "AS_") &
                           ((cmd_q[3] == "V") | (cmd_q[3] == "A")) &
                           ({cmd_q[4], cmd_q[5]} == {`OC_OUT_NUMBER, "="});
  wire       as_audio_w  = cmd_q[3] == "A";
  wire       as_query_w  = is_as_w & (len_q == 4'h7) & (cmd_q[6] == "?");
  wire       st_ok_w     = (cmd_q[6] == "E") | (cmd_q[6] == "D");
  wire       st_en_w     = cmd_q[6] == "E";
  wire       md_ok_w     = (cmd_q[8] == "P") | (cmd_q[8] == "K") | (cmd_q[8] == "L") |
                           (as_audio_w & (cmd_q[8] == "S"));
  wire       ns_ok_w     = (cmd_q[10] == "B") | (cmd_q[10] == "M");
  wire       ns_mute_w   = cmd_q[10] == "M";
  wire       as_set_w    = is_as_w & (len_q == 4'hB) & (cmd_q[7] == ";") &
                           (cmd_q[9] == ";") & st_ok_w & md_ok_w & ns_ok_w;
  wire as_mode_t md_w    = (cmd_q[8] == "P") ? MODE_PRIO :
                           (cmd_q[8] == "K") ? MODE_FIRST :
                           (cmd_q[8] == "L") ? MODE_LAST : MODE_STATIC;
  wire       lk_ok_w     = (is_lock_w | is_unlock_w) & lk_out_ok_w & (mask_w != 2'b00);
  wire resp_kind_t kind_w = ovf_q ? RK_ERR :
                           lk_ok_w ? (is_lock_w ? RK_LOCK : RK_UNLOCK) :
                           (is_vc_w & (mask_w != 2'b00)) ? RK_VIEW :
                           (is_size_w & (mask_w != 2'b00)) ? RK_SIZE :
                           (as_query_w | as_set_w) ? RK_ASEL : RK_ERR;

  // Lock state; an unlock answers the same whether or not the layer was locked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_q <= 2'b00;
    end else if (close_w && kind_w == RK_LOCK) begin
      lock_q <= lock_q | mask_w;
    end else if (close_w && kind_w == RK_UNLOCK) begin
      lock_q <= lock_q & ~mask_w;
    end
  end

  // Autoselect settings
  wire as_apply_w = close_w & ~ovf_q & as_set_w;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vas_en_q   <= `OC_RST_AS_EN;
      vas_mode_q <= MODE_PRIO;
      vas_ns_q   <= `OC_RST_NOSIG;
      aas_en_q   <= `OC_RST_AS_EN;
      aas_mode_q <= MODE_PRIO;
      aas_ns_q   <= `OC_RST_NOSIG;
    end else if (as_apply_w && !as_audio_w) begin
      vas_en_q   <= st_en_w;
      vas_mode_q <= md_w;
      vas_ns_q   <= ns_mute_w;
    end else if (as_apply_w) begin
      aas_en_q   <= st_en_w;
      aas_mode_q <= md_w;
      aas_ns_q   <= ns_mute_w;
    end
  end

  a_asel_apply_video: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (as_apply_w && !as_audio_w) |=> (vas_en_q == $past(st_en_w)) &&
                                    (vas_ns_q == $past(ns_mute_w)) && (kind_q == RK_ASEL))
    else $error("video autoselect change not applied");

  // Switching and muting; one write may switch both layers, a locked one is skipped
  wire xpt_wr_w = wr_w & hit_xpt_w;
  wire vsw_w    = xpt_wr_w & wb_sel_i[0] & ~lock_q[0] & (wb_dat_i[2:0] != 3'h0) &
                  (wb_dat_i[2:0] <= `OC_VID_INPUTS);
  wire asw_w    = xpt_wr_w & wb_sel_i[1] & ~lock_q[1] & (wb_dat_i[10:8] != 3'h0) &
                  (wb_dat_i[10:8] <= `OC_AUD_INPUTS);
  wire mute_w   = wr_w & hit_mute_w & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vsel_q  <= `OC_RST_SEL;
      asel_q  <= `OC_RST_SEL;
      vmute_q <= 1'b0;
      amute_q <= 1'b0;
    end else begin
      if (vsw_w) vsel_q <= wb_dat_i[2:0];
      if (asw_w) asel_q <= wb_dat_i[10:8];
      if (mute_w) begin
        vmute_q <= wb_dat_i[0];
        amute_q <= wb_dat_i[1];
      end
    end
  end

  a_switch_locked: assert property (
    @(posedge clk_i) disable iff (rst_i)
    lock_q[0] |=> $stable(vsel_q))
    else $error("locked video layer changed its connection");

  a_mute_keeps_sel: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mute_w |=> $stable(vsel_q) && $stable(asel_q))
    else $error("mute write altered the crosspoint selection");

  // Overrun flag: set by a dropped character, write one to clear; set wins
  wire ovr_clr_w = wr_w & hit_stat_w & wb_sel_i[0] & wb_dat_i[`OC_STAT_OVR];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovr_q <= 1'b0;
    end else if (rx_wr_w && busy_w) begin
      ovr_q <= 1'b1;
    end else if (ovr_clr_w) begin
      ovr_q <= 1'b0;
    end
  end

  // Response line builder
  wire       lay_lk_w  = cur_audio_q ? lock_q[1] : lock_q[0];
  wire       lay_mt_w  = cur_audio_q ? amute_q : vmute_q;
  wire [7:0] layc_w    = cur_audio_q ? "A" : "V";
  wire [15:0] lay2_w   = (&mask_q) ? "AV" : {8'h00, mask_q[1] ? "A" : "V"};
  wire [7:0] flag_w    = (lay_lk_w & lay_mt_w) ? "U" : lay_mt_w ? "M" :
                         lay_lk_w ? "L" : 8'h00;
  wire [7:0] digit_w   = {5'b00110, cur_audio_q ? asel_q : vsel_q};
  wire [7:0] ncnt_w    = {5'b00110, cur_audio_q ? `OC_AUD_INPUTS : `OC_VID_INPUTS};
  wire       as_en_w   = cur_audio_q ? aas_en_q : vas_en_q;
  wire as_mode_t as_md_w = cur_audio_q ? aas_mode_q : vas_mode_q;
  wire       as_ns_w   = cur_audio_q ? aas_ns_q : vas_ns_q;
  wire [7:0] st_ch_w   = as_en_w ? "E" : "D";
  wire [7:0] ns_ch_w   = as_ns_w ? "M" : "B";
  wire [7:0] md_ch_w   = (as_md_w == MODE_PRIO) ? "P" : (as_md_w == MODE_FIRST) ? "K" :
                         (as_md_w == MODE_LAST) ? "L" : "S";

  // Lines are left aligned in 16 bytes; zero bytes are padding and are skipped
  always_comb begin
    unique case (kind_q)
      RK_LOCK:   line_w = {"(1LO01 ", lay2_w, ")", 16'h0D0A, 32'h0};
      RK_UNLOCK: line_w = {"(0LO01 ", lay2_w, ")", 16'h0D0A, 32'h0};
      RK_VIEW:   line_w = {"(ALL", layc_w, " ", flag_w, "0", digit_w, ")",
                           16'h0D0A, 32'h0};
      RK_SIZE:   line_w = {"(SIZE=", ncnt_w, "x", `OC_OUT_NUMBER, " ", layc_w, ")",
                           16'h0D0A, 16'h0};
      RK_ASEL:   line_w = {"(AS_", layc_w, `OC_OUT_NUMBER, "=", st_ch_w, ";", md_ch_w,
                           ";", ns_ch_w, ")", 16'h0D0A, 8'h0};
      RK_ERR:    line_w = {"(ERR)", 16'h0D0A, 72'h0};
      default:   line_w = {"(ERR)", 16'h0D0A, 72'h0};
    endcase
  end

  for (genvar i = 0; i < 16; i++) begin : g_line_bytes
    assign line_byte_w[i] = line_w[127-8*i -: 8];
  end

  wire [7:0] cur_byte_w = line_byte_w[idx_q];
  wire       step_w     = busy_w & ~full_w;
  wire       wr_en_w    = step_w & (cur_byte_w != 8'h00);

  // Emission sequencer; the audio line follows the video line when a view or size command named both
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q     <= ST_IDLE;
      kind_q      <= RK_ERR;
      mask_q      <= 2'b00;
      idx_q       <= 4'h0;
      second_q    <= 1'b0;
      cur_audio_q <= 1'b0;
    end else if (close_w) begin
      state_q     <= ST_EMIT;
      kind_q      <= kind_w;
      mask_q      <= mask_w;
      idx_q       <= 4'h0;
      second_q    <= ((kind_w == RK_VIEW) | (kind_w == RK_SIZE)) & (&mask_w);
      cur_audio_q <= (kind_w == RK_ASEL) ? as_audio_w : (mask_w == 2'b10);
    end else if (step_w) begin
      idx_q <= idx_q + 4'h1;
      if (idx_q == `OC_LAST_BYTE) begin
        if (second_q) begin
          second_q    <= 1'b0;
          cur_audio_q <= 1'b1;
        end else begin
          state_q <= ST_IDLE;
        end
      end
    end
  end

  a_lock_sets_bits: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (close_w && kind_w == RK_LOCK) |=> ((lock_q & $past(mask_w)) == $past(mask_w)) ##16
                                       (lock_q != 2'b00))
    else $error("lock command did not freeze the layer");

  a_unlock_clears: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (close_w && kind_w == RK_UNLOCK) |=> ((lock_q & $past(mask_w)) == 2'b00))
    else $error("unlock command left the layer locked");

  a_unlock_same_ack: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (close_w && lk_ok_w && is_unlock_w && !ovf_q) |=>
      (kind_q == RK_UNLOCK) && busy_w && (mask_q == $past(mask_w)))
    else $error("unlock answer depends on previous lock state");

  a_view_order: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (step_w && kind_q == RK_VIEW && second_q && idx_q == `OC_LAST_BYTE) |=>
      cur_audio_q && busy_w && (idx_q == 4'h0))
    else $error("view audio line did not follow the video line");

  a_view_digit: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (step_w && kind_q == RK_VIEW && idx_q == 4'h8) |->
      wr_en_w && (cur_byte_w == {5'b00110, cur_audio_q ? asel_q : vsel_q}) &&
      (line_byte_w[7] == "0"))
    else $error("view line input number wrong");

  a_view_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (step_w && kind_q == RK_VIEW && idx_q == 4'h6 && lay_lk_w && lay_mt_w) |->
      (cur_byte_w == "U"))
    else $error("locked and muted layer not flagged U");

  a_size_dims: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (step_w && kind_q == RK_SIZE && idx_q == 4'h6) |->
      (cur_byte_w == (cur_audio_q ? "5" : "6")))
    else $error("reported crosspoint size wrong");

  // Response pointers and memory
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_q  <= '0;
      rd_ptr_q  <= '0;
      wr_seen_q <= '0;
    end else begin
      wr_seen_q <= wr_ptr_q;
      if (wr_en_w) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop_w) rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  resp_mem u_resp_mem (
    .clk_i     (clk_i),
    .wr_en_i   (wr_en_w),
    .wr_addr_i (wr_ptr_q[`OC_RESP_AW-1:0]),
    .wr_data_i (cur_byte_w),
    .rd_addr_i (rd_ptr_q[`OC_RESP_AW-1:0]),
    .rd_data_o (mem_rd_w)
  );

  // Read mux; unmapped offsets read as zero and are acknowledged
  wire [31:0] rdata_w =
    hit_tx_w   ? {23'h0, tx_valid_w, tx_valid_w ? mem_rd_w : 8'h00} :
    hit_stat_w ? {26'h0, amute_q, vmute_q, lock_q, ovr_q, busy_w} :
    hit_xpt_w  ? {21'h0, asel_q, 5'h0, vsel_q} :
    hit_mute_w ? {30'h0, amute_q, vmute_q} :
    hit_asel_w ? {20'h0, aas_ns_q, aas_mode_q, aas_en_q, 4'h0, vas_ns_q, vas_mode_q,
                  vas_en_q} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= req_w;
      dat_q <= rd_w ? rdata_w : 32'h0;
    end
  end

  assign wb_ack_o              = ack_q;
  assign wb_dat_o              = dat_q;
  assign video_sel_o           = vsel_q;
  assign audio_sel_o           = asel_q;
  assign video_mute_o          = vmute_q;
  assign audio_mute_o          = amute_q;
  assign video_lock_o          = lock_q[0];
  assign audio_lock_o          = lock_q[1];
  assign video_as_en_o         = vas_en_q;
  assign video_as_mode_o       = vas_mode_q;
  assign video_as_nosig_mute_o = vas_ns_q;
  assign audio_as_en_o         = aas_en_q;
  assign audio_as_mode_o       = aas_mode_q;
  assign audio_as_nosig_mute_o = aas_ns_q;

endmodule // output_lock_autoselect_commands

// *** bench/host_model.sv ***
/*
  Remote host model: a Wishbone classic master that writes command
  characters and reads answer characters back.
  Assumes one clock shared with the slave and an ack for every request.
*/
`timescale 1ns/100ps

module host_model (
  // Clock
  input  wire logic        clk_i,
  // Slave answer
  input  wire logic        ack_i,
  input  wire logic [31:0] rdat_i,
  // Master request
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [7:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] wdat_o
);
  initial {cyc_o, stb_o, we_o, adr_o, sel_o, wdat_o} = '0;

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, wdat_o} <= {2'b11, w, a, 4'hF, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = rdat_i;
    {cyc_o, stb_o} <= 2'b00;
    // Released data lines must not keep showing the last value
    wdat_o <= ~d;
  endtask
endmodule // host_model

// *** bench/output_lock_autoselect_commands_test.sv ***
/*
  Self-checking bench: commands go in through the RX register, answer
  characters are noted in a queue and compared as the TX reads return.
  Assumes the host model and the design sources are compiled first.
*/
`timescale 1ns/100ps

module output_lock_autoselect_commands_test;
  import ocmd_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, ack, vmu, amu, vlk, alk, ven, vnm, aen, anm;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic [31:0] rnd = 32'h0000000D;
  logic [2:0]  vsel, asel, v;
  as_mode_t    vmd, amd;
  int          errors = 0;
  int          total_checks = 0;
  int          cycles = 0;
  char_t       exp_q[$];

  output_lock_autoselect_commands dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .video_sel_o(vsel), .audio_sel_o(asel),
    .video_mute_o(vmu), .audio_mute_o(amu), .video_lock_o(vlk), .audio_lock_o(alk),
    .video_as_en_o(ven), .video_as_mode_o(vmd), .video_as_nosig_mute_o(vnm),
    .audio_as_en_o(aen), .audio_as_mode_o(amd), .audio_as_nosig_mute_o(anm));
  host_model h (.clk_i(clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .wdat_o(wdat));

  always #50 clk_i = ~clk_i;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Random source: xorshift, seeded with 13
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xorshift = x ^ (x << 5);
  endfunction

  task end_sim;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Sends one command and waits until its whole answer has been read
  task cmd(input string c, input string r);
    int n;
    n = 0;
    foreach (c[i]) h.xfer(1'b1, 8'h00, {24'h0, c[i]}, q);
    foreach (r[i]) exp_q.push_back(r[i]);
    exp_q.push_back(8'h0D);
    exp_q.push_back(8'h0A);
    while (exp_q.size() > 0 && n < 400) begin
      h.xfer(1'b0, 8'h04, 32'h0, q);
      n++;
    end
    chk(exp_q.size(), 0);
  endtask

  always @(posedge clk_i) begin
    if (ack && !we && adr == 8'h04 && rdat[8])
      chk({24'h0, rdat[7:0]}, {24'h0, exp_q.size() ? exp_q.pop_front() : 8'hFF});
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      end_sim();
    end
  end

  initial begin
    string m;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    cmd("{#>01 a}", "(1LO01 A)");
    chk({alk, vlk}, 32'h2);
    cmd("{+<01 V}", "(0LO01 V)");
    rnd = xorshift(rnd);
    v = 3'(rnd % 6) + 3'h1;
    h.xfer(1'b1, 8'h0C, {21'h0, 3'h2, 5'h0, v}, q);
    chk({vsel, asel}, {v, 3'h1});
    h.xfer(1'b1, 8'h10, 32'h1, q);
    chk({amu, vmu, vsel}, {1'b0, 1'b1, v});
    cmd("{vc av}", $sformatf("(ALLV M0%0d)\015\012(ALLA L01)", v));
    cmd("{#>1}", "(1LO01 AV)");
    cmd("{VC V}", $sformatf("(ALLV U0%0d)", v));
    cmd("{+<01}", "(0LO01 AV)");
    cmd("{GetSize av}", "(SIZE=6x1 V)\015\012(SIZE=5x1 A)");
    cmd("{as_v1=?}", "(AS_V1=D;P;B)");
    for (int i = 0; i < 4; i++) begin
      m = "PKLS";
      m = m.substr(i, i);
      cmd($sformatf("{AS_A1=E;%s;M}", m), $sformatf("(AS_A1=E;%s;M)", m));
      chk({aen, amd, anm}, {1'b1, 2'(i), 1'b1});
      if (i < 3) cmd($sformatf("{as_v1=E;%s;M}", m), $sformatf("(AS_V1=E;%s;M)", m));
      if (i < 3) chk({ven, vmd, vnm}, {1'b1, 2'(i), 1'b1});
    end
    cmd("{AS_V1=E;S;B}", "(ERR)");
    cmd("{AS_A2=?}", "(ERR)");
    cmd("{as_a1=?}", "(AS_A1=E;S;M)");
    h.xfer(1'b0, 8'h3C, 32'h0, q);
    chk(q, 32'h0);
    end_sim();
  end
endmodule // output_lock_autoselect_commands_test
